// ==== common/pad_pkg.sv ====
// Constants, codes and types for the terminal service-signal block.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus.
package pad_pkg;
  // Characters used in service signals and data handling
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_DLE = 8'h10;
  localparam logic [7:0] CH_DEL = 8'h7f;
  localparam logic [7:0] CH_CTRL_TOP = 8'h1f;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PARAM_A = 8'h04;
  localparam logic [7:0] OFS_PARAM_B = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields
  localparam int CTRL_PROFILE = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_PAD_MARK = 2;
  localparam int CTRL_ACK_CONN = 3;
  localparam int CTRL_BYPASS = 4;
  localparam int CTRL_LIMIT_LSB = 8;
  // Parameter register fields
  localparam int PA_P1 = 0;
  localparam int PA_P2 = 1;
  localparam int PA_P3_LSB = 8;
  localparam int PA_P4_LSB = 16;
  localparam int PA_P5 = 24;
  localparam int PA_P6 = 25;
  localparam int PB_P7_LSB = 0;
  localparam int PB_P8 = 8;
  localparam int PB_P9_LSB = 16;
  localparam int PB_P10_LSB = 24;
  localparam int ST_WCNT_LSB = 8;
  // Profile defaults
  localparam logic P1_TRANS = 1'b0;
  localparam logic P1_SIMPLE = 1'b1;
  localparam logic P2_DEF = 1'b0;
  localparam logic [7:0] P3_TRANS = 8'h00;
  localparam logic [7:0] P3_SIMPLE = 8'h7e;
  localparam logic [7:0] P4_TRANS = 8'h14;
  localparam logic [7:0] P4_SIMPLE = 8'h00;
  localparam logic P5_TRANS = 1'b0;
  localparam logic P5_SIMPLE = 1'b1;
  localparam logic P6_TRANS = 1'b0;
  localparam logic P6_SIMPLE = 1'b1;
  localparam logic [4:0] P7_DEF = 5'h02;
  localparam logic P8_DEF = 1'b0;
  localparam logic [2:0] P9_DEF = 3'h0;
  localparam logic [7:0] P10_DEF = 8'h00;
  localparam logic [3:0] LIMIT_DEF = 4'h3;
  // Forwarding selections and break actions
  localparam logic [7:0] FWD_CR = 8'h02;
  localparam logic [7:0] FWD_CTRL = 8'h7e;
  localparam logic [4:0] BRK_INT = 5'h01;
  localparam logic [4:0] BRK_RESET = 5'h02;
  localparam logic [4:0] BRK_ESC = 5'h08;
  localparam logic [4:0] BRK_ALL = 5'h15;
  // Timing
  localparam int CLK_NS = 50;
  localparam int IDLE_TICK_MS = 50;
  localparam int IDLE_TICK_CYC = IDLE_TICK_MS * (1000000 / CLK_NS);
  localparam int WAIT_TO_MS = 20000;
  localparam int WAIT_TO_CYC = WAIT_TO_MS * (1000000 / CLK_NS);
  // Service message selectors
  localparam logic [1:0] MSG_CONN = 2'h0;
  localparam logic [1:0] MSG_ERR = 2'h1;
  localparam logic [1:0] MSG_ECHO = 2'h2;
  // Call states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_WAIT = 6'b000010,
    ST_CALL = 6'b000100,
    ST_SVC = 6'b001000,
    ST_DATA = 6'b010000,
    ST_CLEAR = 6'b100000
  } call_state_t;
endpackage

// ==== common/svc_if.sv ====
// Link between the call controller and the service-signal transmitter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface svc_if;
  logic start;
  logic [1:0] msg;
  logic [7:0] echo_ch;
  logic [2:0] pad_cnt;
  logic pad_mark;
  logic ack_opt;
  logic [7:0] fold;
  logic busy;
  modport ctl (output start, msg, echo_ch, pad_cnt, pad_mark, ack_opt, fold, input busy);
  modport tx (input start, msg, echo_ch, pad_cnt, pad_mark, ack_opt, fold, output busy);
endinterface

// ==== tb/pad_term_port_asserts.sv ====
// Checker of bus answers, stream holds and pulses.
// Assumes binding into the port; sees its ports only.
`timescale 1ns/1ps
module pad_term_port_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Terminal and network
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_mark,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic discard_clr,
  input wire logic discard,
  input wire logic brk_int,
  input wire logic brk_reset,
  input wire logic path_drop
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_WR_RESP: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_mark}))
    else $error("tx char moved");
  AST_RX_GAP: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("rx taken twice");
  AST_DISCARD: assert property ($fell(discard) |-> $past(discard_clr) || s_axi_bvalid)
    else $error("discard cleared locally");
  AST_BRK_ONE: assert property (!(brk_int && brk_reset))
    else $error("two break actions");
  AST_DROP: assert property (path_drop |=> !path_drop)
    else $error("path drop too long");
endmodule // pad_term_port_asserts

bind pad_term_port pad_term_port_asserts i_chk (.*);

// ==== tb/tb.sv ====
// Testbench: defaults, profile load, calls with and without signals.
// Assumes the terminal model and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb;
  import pad_pkg::*;
  logic sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, tx_data, net_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [4:0] ev;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic access_up_pin, path_drop, rx_valid, rx_ready, break_in, tx_mark, tx_valid, tx_ready;
  logic call_req, clear_req, vc_up, vc_down, err_evt, discard_clr, net_valid, fwd_now;
  logic brk_int, brk_reset, discard;
  logic [7:0] cm[6] = '{CH_C, CH_O, CH_M, CH_CR, CH_NUL, CH_NUL};
  logic [7:0] er[3] = '{CH_E, CH_R, CH_R};
  int error_cnt = 0;
  int n_compared = 0;
  assign {discard_clr, vc_up, vc_down, err_evt, break_in} = ev;
  wire [3:0] ob = {call_req, net_valid, brk_reset, path_drop};
  pad_term_port #(.IDLE_TICK(20), .WAIT_TO(2000)) i_dut (.*);
  term_model i_term (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #1500000;
    error_cnt++;
    results();
  end
  task results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= d[3:0];
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", RESP_OKAY, s_axi_bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 5'h00;
  endtask
  task automatic await(input int i, input string n);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ob[i] !== 1'b1 && k < 300);
    `CHK(n, 1'b1, ob[i])
  endtask
  task automatic txw(input int n);
    for (int k = 0; k < 400 && i_term.got.size() < n; k++) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    rd(OFS_CTRL, 32'h0000_0300, RESP_OKAY);
    rd(OFS_PARAM_A, 32'h0014_0000, RESP_OKAY);
    rd(OFS_PARAM_B, 32'h0000_0002, RESP_OKAY);
    rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_PARAM_B, 32'h0002_0002);
    wr(OFS_CTRL, 32'h0000_0303);
    rd(OFS_PARAM_A, 32'h0300_7e01, RESP_OKAY);
    rd(OFS_PARAM_B, 32'h0000_0002, RESP_OKAY);
    wr(OFS_PARAM_B, 32'h0002_0002);
  endtask
  task automatic t_call;
    i_term.slow <= 1'b1;
    i_term.line(1'b1);
    i_term.type_ch(CH_CR);
    await(3, "call_req");
    i_term.got.delete();
    pulse(5'h08);
    txw(6);
    for (int i = 0; i < 6; i++)
      `CHK("tx char", {1'b0, cm[i]}, i_term.got[i])
    i_term.type_ch(8'h61);
    await(2, "net_valid");
    `CHK("net_data", 8'h61, net_data)
    repeat (20) @(posedge sys_clk);
    i_term.got.delete();
    pulse(5'h02);
    txw(6);
    for (int i = 0; i < 3; i++)
      `CHK("err char", {1'b0, er[i]}, i_term.got[i])
    pulse(5'h01);
    await(1, "brk_reset");
    wr(OFS_PARAM_B, 32'h0002_0015);
    pulse(5'h01);
    @(negedge sys_clk);
    `CHK("brk", 2'h3, {discard, brk_int})
    pulse(5'h10);
    i_term.line(1'b0);
    await(0, "path_drop");
    `CHK("discard", 1'b0, discard)
  endtask
  task automatic t_quiet;
    wr(OFS_CTRL, 32'h0000_0302);
    i_term.got.delete();
    i_term.line(1'b1);
    i_term.type_ch(CH_CR);
    await(3, "call_req");
    pulse(5'h08);
    i_term.type_ch(8'h62);
    await(2, "net_valid");
    `CHK("net_data", 8'h62, net_data)
    `CHK("tx count", 0, i_term.got.size())
    pulse(5'h04);
    await(0, "path_drop");
  endtask
  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    ev = 5'h00;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_call();
    t_quiet();
    results();
  end
endmodule // tb

// ==== tb/term_model.sv ====
// Terminal model: types characters, takes what is sent.
// Assumes the port's character handshakes on sys_clk.
`timescale 1ns/1ps
module term_model (
  // Clock
  input wire logic sys_clk,
  // Toward the port
  output logic access_up_pin,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // From the port
  input wire logic [7:0] tx_data,
  input wire logic tx_mark,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [8:0] got[$];
  logic slow = 1'b0;
  initial begin
    access_up_pin = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // Takes chars, stalling every other cycle when slow
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready)
      got.push_back({tx_mark, tx_data});
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // Connects or clears by the access path
  task automatic line(input logic up);
    @(posedge sys_clk);
    access_up_pin <= up;
  endtask
  // Holds a char until taken
  task automatic type_ch(input logic [7:0] c);
    @(posedge sys_clk);
    rx_data <= c;
    rx_valid <= 1'b1;
    do @(posedge sys_clk); while (!rx_ready);
    rx_valid <= 1'b0;
    rx_data <= ~c;
  endtask
endmodule // term_model

// ==== verilog/pad_term_port.sv ====
// Call sequencing, parameter profiles and service signals for one terminal port.
// Assumes a byte-level receiver and transmitter on sys_clk and an AXI4-Lite master.
// Functional notes
// - Error signal starts with E R R
// - Padding is NUL or one idle mark; the code sends pad_cnt NULs, each with tx_mark set when pad_mark is set
// - Connected signal is COM, or ACK option
// - Suppressed signals: advance on call established
// - Suppressed signals skip state 8
// - All service signals sent in state 8
// - Waiting state entered N times, then clear
// - Bypassed states 2-4 run no time-outs
// - Terminal disconnect answered by clearing, disconnecting
// - Escape recall default 0 transparent, 1 simple
// - Echo defaults off; 1 echoes characters
// - Forwarding 0, 2 CR, 126 controls+DEL
// - Idle timer in 50 ms, 0 disables
// - Flow control default 0 transparent, 1 simple
// - Service signals default 0 transparent, 1 simple
// - Break action 0,1,2,8,21; default 2
// - Discard set by device, cleared remotely
// - 0 to 7 pads after carriage return
// - Line folding 1 to 255; 0 off
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pad_term_port
  import pad_pkg::*;
#(
  parameter int IDLE_TICK = IDLE_TICK_CYC,
  parameter int WAIT_TO = WAIT_TO_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Terminal access path and characters
  input wire logic access_up_pin,
  output logic path_drop,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic break_in,
  output logic [7:0] tx_data,
  output logic tx_mark,
  output logic tx_valid,
  input wire logic tx_ready,
  // Network side
  output logic call_req,
  output logic clear_req,
  input wire logic vc_up,
  input wire logic vc_down,
  input wire logic err_evt,
  input wire logic discard_clr,
  output logic [7:0] net_data,
  output logic net_valid,
  output logic fwd_now,
  output logic brk_int,
  output logic brk_reset,
  output logic discard
);
  svc_if sif ();

  svc_tx u_tx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .s(sif.tx),
    .tx_data(tx_data),
    .tx_mark(tx_mark),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  function automatic logic [2:0] decode(input logic [7:0] a);
    if (a == OFS_CTRL) begin
      decode = 3'b100;
    end else if (a == OFS_PARAM_A) begin
      decode = 3'b101;
    end else if (a == OFS_PARAM_B) begin
      decode = 3'b110;
    end else if (a == OFS_STATUS) begin
      decode = 3'b111;
    end else begin
      decode = 3'b000;
    end
  endfunction

  call_state_t st_q, st_d, ret_q, ret_d;
  logic acc_s1, acc_s2, acc_s3, acc_q, acc_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic profile_q, profile_d, pad_mark_q, pad_mark_d, ack_q, ack_d, byp_q, byp_d;
  logic [3:0] limit_q, limit_d, wcnt_q, wcnt_d;
  logic p1_q, p1_d, p2_q, p2_d, p5_q, p5_d, p6_q, p6_d, p8_q, p8_d;
  logic [7:0] p3_q, p3_d, p4_q, p4_d, p10_q, p10_d;
  logic [4:0] p7_q, p7_d;
  logic [2:0] p9_q, p9_d;
  logic [31:0] tick_q, tick_d, xcnt_q, xcnt_d;
  logic [7:0] idle_q, idle_d;
  logic armed_q, armed_d;
  logic start_q, start_d;
  logic [1:0] msg_q, msg_d;
  logic [7:0] echo_q, echo_d, net_q, net_d;
  logic rx_rdy_q, rx_rdy_d, netv_q, netv_d, fwd_q, fwd_d;
  logic call_q, call_d, clr_q, clr_d, drop_q, drop_d, bi_q, bi_d, br_q, br_d;

  always_comb begin
    logic [2:0] wsel, rsel;
    logic do_wr, load, take, enter_wait, fwd_char;
    wsel = decode(awaddr_q);
    rsel = decode(s_axi_araddr);
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    profile_d = profile_q;
    pad_mark_d = pad_mark_q;
    ack_d = ack_q;
    byp_d = byp_q;
    limit_d = limit_q;
    {p1_d, p2_d, p3_d, p4_d, p5_d} = {p1_q, p2_q, p3_q, p4_q, p5_q};
    {p6_d, p7_d, p8_d, p9_d, p10_d} = {p6_q, p7_q, p8_q, p9_q, p10_q};
    load = 1'b0;
    // Bus write channels
    if (s_axi_awvalid && !aw_full_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    do_wr = aw_full_q && w_full_q && !bvalid_q;
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wsel[2] ? RESP_OKAY : RESP_SLVERR;
      if (wsel == 3'b100) begin
        profile_d = wdata_q[CTRL_PROFILE];
        pad_mark_d = wdata_q[CTRL_PAD_MARK];
        ack_d = wdata_q[CTRL_ACK_CONN];
        byp_d = wdata_q[CTRL_BYPASS];
        limit_d = wdata_q[CTRL_LIMIT_LSB +: 4];
        load = wdata_q[CTRL_LOAD];
      end else if (wsel == 3'b101) begin
        p1_d = wdata_q[PA_P1];
        p2_d = wdata_q[PA_P2];
        p3_d = wdata_q[PA_P3_LSB +: 8];
        p4_d = wdata_q[PA_P4_LSB +: 8];
        p5_d = wdata_q[PA_P5];
        p6_d = wdata_q[PA_P6];
      end else if (wsel == 3'b110) begin
        p7_d = wdata_q[PB_P7_LSB +: 5];
        p8_d = wdata_q[PB_P8];
        p9_d = wdata_q[PB_P9_LSB +: 3];
        p10_d = wdata_q[PB_P10_LSB +: 8];
      end
    end
    if (load) begin
      p1_d = profile_d ? P1_SIMPLE : P1_TRANS;
      p2_d = P2_DEF;
      p3_d = profile_d ? P3_SIMPLE : P3_TRANS;
      p4_d = profile_d ? P4_SIMPLE : P4_TRANS;
      p5_d = profile_d ? P5_SIMPLE : P5_TRANS;
      p6_d = profile_d ? P6_SIMPLE : P6_TRANS;
      p7_d = P7_DEF;
      p8_d = P8_DEF;
      p9_d = P9_DEF;
      p10_d = P10_DEF;
    end
    // Bus read channel
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = rsel[2] ? RESP_OKAY : RESP_SLVERR;
      rdata_d = 32'h0;
      if (rsel == 3'b100) begin
        rdata_d[CTRL_PROFILE] = profile_q;
        rdata_d[CTRL_PAD_MARK] = pad_mark_q;
        rdata_d[CTRL_ACK_CONN] = ack_q;
        rdata_d[CTRL_BYPASS] = byp_q;
        rdata_d[CTRL_LIMIT_LSB +: 4] = limit_q;
      end else if (rsel == 3'b101) begin
        rdata_d[PA_P1] = p1_q;
        rdata_d[PA_P2] = p2_q;
        rdata_d[PA_P3_LSB +: 8] = p3_q;
        rdata_d[PA_P4_LSB +: 8] = p4_q;
        rdata_d[PA_P5] = p5_q;
        rdata_d[PA_P6] = p6_q;
      end else if (rsel == 3'b110) begin
        rdata_d[PB_P7_LSB +: 5] = p7_q;
        rdata_d[PB_P8] = p8_q;
        rdata_d[PB_P9_LSB +: 3] = p9_q;
        rdata_d[PB_P10_LSB +: 8] = p10_q;
      end else if (rsel == 3'b111) begin
        rdata_d[5:0] = st_q;
        rdata_d[ST_WCNT_LSB +: 4] = wcnt_q;
      end
    end
    // Access path synchroniser: change counts once stages two and three agree
    acc_d = (acc_s2 == acc_s3) ? acc_s3 : acc_q;
    // Call state machine
    st_d = st_q;
    ret_d = ret_q;
    wcnt_d = wcnt_q;
    xcnt_d = xcnt_q;
    tick_d = tick_q;
    idle_d = idle_q;
    armed_d = armed_q;
    start_d = 1'b0;
    msg_d = msg_q;
    echo_d = echo_q;
    net_d = net_q;
    {netv_d, fwd_d, call_d, clr_d, drop_d, bi_d, br_d} = 7'h00;
    take = rx_valid && rx_rdy_q;
    enter_wait = 1'b0;
    fwd_char = (p3_q == FWD_CR && rx_data == CH_CR) ||
      (p3_q == FWD_CTRL && (rx_data <= CH_CTRL_TOP || rx_data == CH_DEL));
    if (discard_clr) begin
      p8_d = 1'b0;
    end
    case (st_q)
      ST_IDLE: begin
        wcnt_d = 4'h0;
        if (acc_q) begin
          if (byp_q) begin
            st_d = ST_CALL;
            call_d = 1'b1;
          end else begin
            enter_wait = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        xcnt_d = xcnt_q + 32'h1;
        if (take && rx_data == CH_CR) begin
          st_d = ST_CALL;
          call_d = 1'b1;
        end else if (xcnt_q >= 32'(WAIT_TO - 1)) begin
          enter_wait = 1'b1;
        end
      end
      ST_CALL: begin
        if (vc_down) begin
          st_d = ST_CLEAR;
        end else if (vc_up && p6_q) begin
          st_d = ST_SVC;
          ret_d = ST_DATA;
          start_d = 1'b1;
          msg_d = MSG_CONN;
        end else if (vc_up) begin
          st_d = ST_DATA;
        end
      end
      ST_SVC: begin
        if (!start_q && !sif.busy) begin
          st_d = ret_q;
        end
      end
      ST_DATA: begin
        if (tick_q >= 32'(IDLE_TICK - 1)) begin
          tick_d = 32'h0;
          idle_d = idle_q + 8'h01;
        end else begin
          tick_d = tick_q + 32'h1;
        end
        if (armed_q && p4_q != 8'h00 && idle_q == p4_q) begin
          fwd_d = 1'b1;
          armed_d = 1'b0;
        end
        if (vc_down) begin
          st_d = ST_CLEAR;
        end else if (break_in) begin
          if (p7_q == BRK_INT || p7_q == BRK_ALL) begin
            bi_d = 1'b1;
          end
          if (p7_q == BRK_ALL) begin
            p8_d = 1'b1;
          end
          if (p7_q == BRK_RESET) begin
            br_d = 1'b1;
          end
          if (p7_q == BRK_ESC) begin
            enter_wait = 1'b1;
          end
        end else if (err_evt && p6_q) begin
          st_d = ST_SVC;
          ret_d = ST_DATA;
          start_d = 1'b1;
          msg_d = MSG_ERR;
        end else if (take) begin
          tick_d = 32'h0;
          idle_d = 8'h00;
          armed_d = 1'b1;
          if (p1_q && rx_data == CH_DLE) begin
            enter_wait = 1'b1;
          end else begin
            net_d = rx_data;
            netv_d = 1'b1;
            fwd_d = fwd_char;
            if (p2_q && !sif.busy) begin
              start_d = 1'b1;
              msg_d = MSG_ECHO;
              echo_d = rx_data;
            end
          end
        end
      end
      ST_CLEAR: begin
        clr_d = 1'b1;
        drop_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (enter_wait) begin
      xcnt_d = 32'h0;
      if (wcnt_q == limit_q) begin
        st_d = ST_CLEAR;
      end else begin
        wcnt_d = wcnt_q + 4'h1;
        st_d = ST_WAIT;
      end
    end
    if (!acc_q && st_q != ST_IDLE && st_q != ST_CLEAR) begin
      st_d = ST_CLEAR;
    end
    rx_rdy_d = (st_d == ST_WAIT || st_d == ST_DATA) && !load && !take &&
      !(p2_q && sif.busy);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {acc_s1, acc_s2, acc_s3, acc_q} <= 4'h0;
      {aw_full_q, w_full_q, bvalid_q, rvalid_q} <= 4'h0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      rdata_q <= 32'h0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      {profile_q, pad_mark_q, ack_q, byp_q} <= 4'h0;
      limit_q <= LIMIT_DEF;
      p1_q <= P1_TRANS;
      p2_q <= P2_DEF;
      p3_q <= P3_TRANS;
      p4_q <= P4_TRANS;
      p5_q <= P5_TRANS;
      p6_q <= P6_TRANS;
      p7_q <= P7_DEF;
      p8_q <= P8_DEF;
      p9_q <= P9_DEF;
      p10_q <= P10_DEF;
      st_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      wcnt_q <= 4'h0;
      xcnt_q <= 32'h0;
      tick_q <= 32'h0;
      idle_q <= 8'h00;
      armed_q <= 1'b0;
      start_q <= 1'b0;
      msg_q <= MSG_CONN;
      echo_q <= 8'h00;
      net_q <= 8'h00;
      {rx_rdy_q, netv_q, fwd_q, call_q, clr_q, drop_q, bi_q, br_q} <= 8'h00;
    end else begin
      acc_s1 <= access_up_pin;
      acc_s2 <= acc_s1;
      acc_s3 <= acc_s2;
      acc_q <= acc_d;
      {aw_full_q, w_full_q, bvalid_q, rvalid_q} <= {aw_full_d, w_full_d, bvalid_d, rvalid_d};
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      {profile_q, pad_mark_q, ack_q, byp_q} <= {profile_d, pad_mark_d, ack_d, byp_d};
      limit_q <= limit_d;
      {p1_q, p2_q, p3_q, p4_q, p5_q} <= {p1_d, p2_d, p3_d, p4_d, p5_d};
      {p6_q, p7_q, p8_q, p9_q, p10_q} <= {p6_d, p7_d, p8_d, p9_d, p10_d};
      st_q <= st_d;
      ret_q <= ret_d;
      wcnt_q <= wcnt_d;
      xcnt_q <= xcnt_d;
      tick_q <= tick_d;
      idle_q <= idle_d;
      armed_q <= armed_d;
      start_q <= start_d;
      msg_q <= msg_d;
      echo_q <= echo_d;
      net_q <= net_d;
      {rx_rdy_q, netv_q, fwd_q, call_q} <= {rx_rdy_d, netv_d, fwd_d, call_d};
      {clr_q, drop_q, bi_q, br_q} <= {clr_d, drop_d, bi_d, br_d};
    end
  end

  // Controller side of the transmitter link
  assign sif.start = start_q;
  assign sif.msg = msg_q;
  assign sif.echo_ch = echo_q;
  assign sif.pad_cnt = p9_q;
  assign sif.pad_mark = pad_mark_q;
  assign sif.ack_opt = ack_q;
  assign sif.fold = p10_q;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rx_ready = rx_rdy_q;
  assign net_data = net_q;
  assign net_valid = netv_q;
  assign fwd_now = fwd_q;
  assign call_req = call_q;
  assign clear_req = clr_q;
  assign path_drop = drop_q;
  assign brk_int = bi_q;
  assign brk_reset = br_q;
  assign discard = p8_q;
endmodule // pad_term_port

// ==== verilog/svc_tx.sv ====
// Service-signal and echo character transmitter with padding and folding.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
module svc_tx
  import pad_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Controller side
  svc_if.tx s,
  // Terminal character stream
  output logic [7:0] tx_data,
  output logic tx_mark,
  output logic tx_valid,
  input wire logic tx_ready
);
  logic [7:0] seq_q [0:3];
  logic [7:0] seq_d [0:3];
  logic [2:0] len_q, len_d, idx_q, idx_d, pad_q, pad_d;
  logic [7:0] col_q, col_d, data_q, data_d;
  logic mark_q, mark_d, valid_q, valid_d, busy_q, busy_d;
  logic [7:0] ch;

  always_comb begin
    seq_d = seq_q;
    len_d = len_q;
    idx_d = idx_q;
    pad_d = pad_q;
    col_d = col_q;
    data_d = data_q;
    mark_d = mark_q;
    valid_d = valid_q && !tx_ready;
    ch = seq_q[idx_q[1:0]];
    if (!valid_q || tx_ready) begin
      if (pad_q != 3'h0) begin
        data_d = CH_NUL;
        mark_d = s.pad_mark;
        valid_d = 1'b1;
        pad_d = pad_q - 3'h1;
      end else if (idx_q != len_q) begin
        valid_d = 1'b1;
        mark_d = 1'b0;
        if (s.fold != 8'h00 && col_q == s.fold && ch != CH_CR) begin
          data_d = CH_CR;
          col_d = 8'h00;
          pad_d = s.pad_cnt;
        end else begin
          data_d = ch;
          idx_d = idx_q + 3'h1;
          col_d = (ch == CH_CR) ? 8'h00 : col_q + 8'h01;
          if (ch == CH_CR) begin
            pad_d = s.pad_cnt;
          end
        end
      end else if (s.start) begin
        idx_d = 3'h0;
        if (s.msg == MSG_CONN && s.ack_opt) begin
          seq_d[0] = CH_ACK;
          len_d = 3'h1;
        end else if (s.msg == MSG_CONN) begin
          seq_d[0] = CH_C;
          seq_d[1] = CH_O;
          seq_d[2] = CH_M;
          seq_d[3] = CH_CR;
          len_d = 3'h4;
        end else if (s.msg == MSG_ERR) begin
          seq_d[0] = CH_E;
          seq_d[1] = CH_R;
          seq_d[2] = CH_R;
          seq_d[3] = CH_CR;
          len_d = 3'h4;
        end else begin
          seq_d[0] = s.echo_ch;
          len_d = 3'h1;
        end
      end
    end
    busy_d = (idx_d != len_d) || (pad_d != 3'h0) || valid_d;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        seq_q[i] <= 8'h00;
      end
      len_q <= 3'h0;
      idx_q <= 3'h0;
      pad_q <= 3'h0;
      col_q <= 8'h00;
      data_q <= 8'h00;
      mark_q <= 1'b0;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      len_q <= len_d;
      idx_q <= idx_d;
      pad_q <= pad_d;
      col_q <= col_d;
      data_q <= data_d;
      mark_q <= mark_d;
      valid_q <= valid_d;
      busy_q <= busy_d;
    end
  end

  assign tx_data = data_q;
  assign tx_mark = mark_q;
  assign tx_valid = valid_q;
  assign s.busy = busy_q;
endmodule // svc_tx
